// >>> src/alsenc_map.svh
// timing constants and register map of the alarm and indicator encoder
`ifndef ALSENC_MAP_SVH
`define ALSENC_MAP_SVH
// clock
`define ALSENC_CLK_MHZ 100
// power-good lead time before output loss, in microseconds
`define ALSENC_PG_LEAD_US 5000
`define ALSENC_PG_LEAD_CYC (`ALSENC_PG_LEAD_US * `ALSENC_CLK_MHZ)
// default blink half period and power-good pulse half period, in cycles
`define ALSENC_BLINK_HALF 25000000
`define ALSENC_PULSE_HALF 5000000
// register byte offsets
`define ALSENC_OFS_CTRL 4'h0
`define ALSENC_OFS_COND 4'h4
`define ALSENC_OFS_STRAP 4'h8
`define ALSENC_OFS_PINS 4'hC
// control register fields
`define ALSENC_CTRL_BUSOFF 0
`define ALSENC_CTRL_ALERT0 1
`define ALSENC_CTRL_ALERT1 2
`define ALSENC_CTRL_RST 32'h0000_0000
`endif

// >>> src/alsenc_pkg.sv
// types of the alarm and indicator encoder
package alsenc_pkg;
    // indicator colour
    typedef enum logic [1:0] {ALSENC_OFF = 2'h0, ALSENC_GREEN = 2'h1, ALSENC_RED = 2'h2,
        ALSENC_BLINK = 2'h3} alsenc_led_e;
    // selected condition, in priority order
    typedef enum logic [3:0] {
        ALSENC_NORMAL = 4'h0, ALSENC_OTWARN = 4'h1, ALSENC_OCUR = 4'h3,
        ALSENC_REMOFF = 4'h2, ALSENC_RANGE = 4'h6, ALSENC_NOIN = 4'h7,
        ALSENC_OVP = 4'h5, ALSENC_OTFAULT = 4'h4
    } alsenc_cond_e;
    // raw internal conditions
    typedef struct packed {
        logic inputPresent;
        logic inputInRange;
        logic outputOvervoltage;
        logic overcurrent;
        logic thermalWarning;
        logic thermalFault;
        logic outputFalling;
        logic powerLimited;
    } alsenc_cond_s;
    // pin levels driven to the controller
    typedef struct packed {
        logic faultN;
        logic outputGoodN;
        logic thermalWarningN;
        logic powerCapN;
        logic alert0N;
        logic alert1N;
    } alsenc_alarm_s;
endpackage : alsenc_pkg

// >>> src/alsenc_top.sv
// alarm, indicator and hardware control encoder of a rectifier module
`timescale 1ns/100ps
`include "alsenc_map.svh"
//
// Contract
// R1: normal: both green, alarms high
// R2: bad input range: blink input, output off
// R3: no input: both off, good low
// R4: overvoltage: output red, fault and good low
// R5: overcurrent: blink output, pulse good
// R6: thermal warning: only warning low
// R7: thermal fault: output red, three alarms low
// R8: remote off: output off, good low
// R9: good low lead time before output loss
// R10: fault low while fault present
// R11: warning low near thermal shutdown
// R12: capacity low when power limited
// R13: output enabled only while on/off low
// R14: interlock gates main output
// R15: address pins open read one
// R16: range pin selects dc range
// R17: standby 3.3V, 5V when grounded
// R18: alerts active low, open drain
// R19: controller turns off by pin or bus
// R20: blink and pulse periods are parameters
// R21: faults over warnings over normal
module alsenc_top #(
    parameter int unsigned BLINK_HALF = `ALSENC_BLINK_HALF,
    parameter int unsigned PULSE_HALF = `ALSENC_PULSE_HALF,
    parameter int unsigned PG_LEAD_CYC = `ALSENC_PG_LEAD_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    // avalon slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // internal conditions
    input wire alsenc_pkg::alsenc_cond_s condIn,
    // control pins
    input wire logic remoteOnOffN,
    input wire logic interlockN,
    input wire logic [2:0] bus_address_select,
    input wire logic dc_range_select,
    input wire logic standbySelectN,
    // outputs
    output logic mainOutputEnable,
    output logic dcRangeNarrow,
    output logic standbyHigh,
    output logic [2:0] busAddress,
    output logic [1:0] input_indicator,
    output logic [1:0] output_indicator,
    output logic faultN,
    output logic faultOeN,
    output logic output_good_n,
    output logic outputGoodOeN,
    output logic thermal_warning_n,
    output logic thermalWarningOeN,
    output logic powerCapN,
    output logic powerCapOeN,
    output logic alert0N,
    output logic alert0OeN,
    output logic alert1N,
    output logic alert1OeN,
    output logic module_present
);
    // =====================================================
    // declarations
    // =====================================================
    logic [31:0] ctrl; // software control bits
    logic [31:0] next_ctrl;
    logic [31:0] readData; // read data register
    logic [31:0] next_readData;
    logic ackDone; // answer phase of the current access
    logic next_ackDone;
    logic [31:0] blinkCnt; // blink timer
    logic [31:0] next_blinkCnt;
    logic blinkPh; // blink phase
    logic next_blinkPh;
    logic [31:0] pulseCnt; // good pulse timer
    logic [31:0] next_pulseCnt;
    logic pulsePh; // pulse phase
    logic next_pulsePh;
    logic [31:0] leadCnt; // lead time since output falling seen
    logic [31:0] next_leadCnt;
    logic [5:0] strap; // strap pins sampled on every clock
    logic [5:0] next_strap;
    alsenc_pkg::alsenc_cond_e cond; // chosen condition
    alsenc_pkg::alsenc_cond_e next_cond;
    alsenc_pkg::alsenc_alarm_s alarm; // alarm levels register
    alsenc_pkg::alsenc_alarm_s next_alarm;
    logic [3:0] leds; // indicator register
    logic [3:0] next_leds;
    logic outEn; // main output enable register
    logic next_outEn;
    logic remoteOff; // any remote off request

    // merge a byte-enabled write into a word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
        input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // one-hot free encoding of indicator colour
    function automatic logic [1:0] ledOut(input alsenc_pkg::alsenc_led_e c, input logic ph);
        if (c == alsenc_pkg::ALSENC_BLINK)
            return ph ? 2'(alsenc_pkg::ALSENC_GREEN) : 2'(alsenc_pkg::ALSENC_OFF);
        return 2'(c);
    endfunction : ledOut

    // =====================================================
    // bus slave
    // =====================================================
    assign remoteOff = remoteOnOffN | ctrl[`ALSENC_CTRL_BUSOFF]; // R19

    // one wait cycle then answer; unmapped reads zero, writes dropped
    always_comb
    begin
        next_ctrl = ctrl;
        next_readData = readData;
        next_ackDone = 1'b0;
        if ((avs_read || avs_write) && !ackDone)
        begin
            next_ackDone = 1'b1;
            if (avs_write && avs_address == `ALSENC_OFS_CTRL)
                next_ctrl = merge(ctrl, avs_writedata, avs_byteenable) & 32'h0000_0007;
            unique case (avs_address)
                `ALSENC_OFS_CTRL: next_readData = ctrl;
                `ALSENC_OFS_COND: next_readData = {20'h0_0000, 4'(cond), 8'(condIn)};
                `ALSENC_OFS_STRAP: next_readData = {26'h000_0000, strap};
                `ALSENC_OFS_PINS: next_readData = {23'h00_0000, outEn, leds, 4'(alarm[5:2])};
                default: next_readData = 32'h0000_0000;
            endcase
        end
    end

    // bus registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl <= `ALSENC_CTRL_RST;
            readData <= 32'h0000_0000;
            ackDone <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            readData <= next_readData;
            ackDone <= next_ackDone;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ackDone;
    assign avs_readdata = readData;

    // =====================================================
    // timers and strap capture
    // =====================================================
    // blink and pulse generators, lead timer, straps
    always_comb
    begin
        next_blinkCnt = blinkCnt + 32'h0000_0001; // R20
        next_blinkPh = blinkPh;
        if (blinkCnt >= BLINK_HALF - 1)
        begin
            next_blinkCnt = 32'h0000_0000;
            next_blinkPh = !blinkPh;
        end
        next_pulseCnt = pulseCnt + 32'h0000_0001; // R20
        next_pulsePh = pulsePh;
        if (pulseCnt >= PULSE_HALF - 1)
        begin
            next_pulseCnt = 32'h0000_0000;
            next_pulsePh = !pulsePh;
        end
        // count from the first sign of falling output; saturate
        if (!condIn.outputFalling)
            next_leadCnt = 32'h0000_0000;
        else if (leadCnt < PG_LEAD_CYC)
            next_leadCnt = leadCnt + 32'h0000_0001;
        else
            next_leadCnt = leadCnt;
        // straps: address (R15), range (R16), standby (R17)
        // top bit unused, held high like an open strap
        next_strap = {1'b1, standbySelectN, dc_range_select, bus_address_select};
    end

    // timer registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            blinkCnt <= 32'h0000_0000;
            blinkPh <= 1'b0;
            pulseCnt <= 32'h0000_0000;
            pulsePh <= 1'b0;
            leadCnt <= 32'h0000_0000;
            strap <= 6'h3F;
        end
        else
        begin
            blinkCnt <= next_blinkCnt;
            blinkPh <= next_blinkPh;
            pulseCnt <= next_pulseCnt;
            pulsePh <= next_pulsePh;
            leadCnt <= next_leadCnt;
            strap <= next_strap;
        end
    end

    // =====================================================
    // condition encoder
    // =====================================================
    // fixed priority: thermal fault, overvoltage, no input, range, remote, overcurrent, warning
    always_comb
    begin
        if (condIn.thermalFault)
            next_cond = alsenc_pkg::ALSENC_OTFAULT; // R21
        else if (condIn.outputOvervoltage)
            next_cond = alsenc_pkg::ALSENC_OVP;
        else if (!condIn.inputPresent)
            next_cond = alsenc_pkg::ALSENC_NOIN;
        else if (!condIn.inputInRange)
            next_cond = alsenc_pkg::ALSENC_RANGE;
        else if (remoteOff)
            next_cond = alsenc_pkg::ALSENC_REMOFF;
        else if (condIn.overcurrent)
            next_cond = alsenc_pkg::ALSENC_OCUR;
        else if (condIn.thermalWarning)
            next_cond = alsenc_pkg::ALSENC_OTWARN;
        else
            next_cond = alsenc_pkg::ALSENC_NORMAL;
    end

    // output map from the chosen condition
    always_comb
    begin
        alsenc_pkg::alsenc_led_e inC;
        alsenc_pkg::alsenc_led_e outC;
        inC = alsenc_pkg::ALSENC_GREEN;
        outC = alsenc_pkg::ALSENC_GREEN;
        next_alarm = '1;
        unique case (cond)
            alsenc_pkg::ALSENC_NORMAL: ; // R1
            alsenc_pkg::ALSENC_RANGE:
            begin
                inC = alsenc_pkg::ALSENC_BLINK; // R2
                outC = alsenc_pkg::ALSENC_OFF;
            end
            alsenc_pkg::ALSENC_NOIN:
            begin
                inC = alsenc_pkg::ALSENC_OFF; // R3
                outC = alsenc_pkg::ALSENC_OFF;
                next_alarm.outputGoodN = 1'b0;
            end
            alsenc_pkg::ALSENC_OVP:
            begin
                outC = alsenc_pkg::ALSENC_RED; // R4
                next_alarm.faultN = 1'b0; // R10
                next_alarm.outputGoodN = 1'b0;
            end
            alsenc_pkg::ALSENC_OCUR:
            begin
                outC = alsenc_pkg::ALSENC_BLINK; // R5
                next_alarm.outputGoodN = pulsePh;
            end
            alsenc_pkg::ALSENC_OTWARN: next_alarm.thermalWarningN = 1'b0; // R6 R11
            alsenc_pkg::ALSENC_OTFAULT:
            begin
                outC = alsenc_pkg::ALSENC_RED; // R7
                next_alarm.faultN = 1'b0;
                next_alarm.outputGoodN = 1'b0;
                next_alarm.thermalWarningN = 1'b0;
            end
            alsenc_pkg::ALSENC_REMOFF:
            begin
                outC = alsenc_pkg::ALSENC_OFF; // R8
                next_alarm.outputGoodN = 1'b0;
            end
        endcase
        // early warning of output loss
        if (leadCnt != 32'h0000_0000)
            next_alarm.outputGoodN = 1'b0; // R9
        next_alarm.powerCapN = !condIn.powerLimited; // R12
        next_alarm.alert0N = !ctrl[`ALSENC_CTRL_ALERT0]; // R18
        next_alarm.alert1N = !ctrl[`ALSENC_CTRL_ALERT1];
        next_leds = {ledOut(inC, blinkPh), ledOut(outC, blinkPh)};
        // output on only with on/off low, interlock made and no fault state
        next_outEn = !remoteOnOffN && !interlockN && !ctrl[`ALSENC_CTRL_BUSOFF] // R13 R14
            && cond != alsenc_pkg::ALSENC_OTFAULT && cond != alsenc_pkg::ALSENC_OVP
            && condIn.inputPresent && condIn.inputInRange;
    end

    // output registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cond <= alsenc_pkg::ALSENC_NORMAL;
            alarm <= '1;
            leds <= 4'h0;
            outEn <= 1'b0;
        end
        else
        begin
            cond <= next_cond;
            alarm <= next_alarm;
            leds <= next_leds;
            outEn <= next_outEn;
        end
    end

    // =====================================================
    // pins
    // =====================================================
    assign mainOutputEnable = outEn;
    assign input_indicator = leds[3:2];
    assign output_indicator = leds[1:0];
    assign busAddress = strap[2:0]; // R15
    assign dcRangeNarrow = !strap[3]; // R16
    assign standbyHigh = !strap[4]; // R17
    // open drain: output low, enable low only while pulling down
    assign faultN = 1'b0;
    assign faultOeN = alarm.faultN;
    assign output_good_n = 1'b0;
    assign outputGoodOeN = alarm.outputGoodN;
    assign thermal_warning_n = 1'b0;
    assign thermalWarningOeN = alarm.thermalWarningN;
    assign powerCapN = 1'b0;
    assign powerCapOeN = alarm.powerCapN;
    assign alert0N = 1'b0; // R18
    assign alert0OeN = alarm.alert0N;
    assign alert1N = 1'b0;
    assign alert1OeN = alarm.alert1N;
    assign module_present = 1'b0;
endmodule : alsenc_top

// >>> testbench/alsenc_checker.sv
// concurrent checks on the pins of the alarm and indicator encoder
`timescale 1ns/100ps
module alsenc_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire alsenc_pkg::alsenc_cond_s condIn,
    input wire logic remoteOnOffN,
    input wire logic interlockN,
    input wire logic mainOutputEnable,
    input wire logic [1:0] input_indicator,
    input wire logic [1:0] output_indicator,
    input wire logic faultOeN,
    input wire logic outputGoodOeN,
    input wire logic thermalWarningOeN,
    input wire logic powerCapOeN
);
    // remote pin and conditions one and two cycles back
    logic [8:0] s1, s2, next_s1, next_s2;
    // both samples agree, so the two-cycle pin pipeline has settled
    logic steady;
    assign steady = s1 == s2;
    // ==========================================
    // input history
    always_comb
    begin
        next_s1 = {remoteOnOffN, condIn};
        next_s2 = s1;
    end
    // unequal reset values keep every check but a_enable quiet until real samples land
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1 <= 9'h1FF;
            s2 <= 9'h000;
        end
        else
        begin
            s1 <= next_s1;
            s2 <= next_s2;
        end
    end
    // ==========================================
    // pin picture per condition
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    property p_normal;
        steady && s2 == 9'h0C0 |-> input_indicator == 2'h1 && output_indicator == 2'h1
            && faultOeN && outputGoodOeN && thermalWarningOeN;
    endproperty
    a_normal: assert property (p_normal) else $error("normal picture wrong");
    property p_noin;
        steady && !s2[7] && !s2[5] && !s2[2] |-> input_indicator == 2'h0
            && output_indicator == 2'h0 && faultOeN && !outputGoodOeN && thermalWarningOeN;
    endproperty
    a_noin: assert property (p_noin) else $error("no input picture wrong");
    property p_overvolt;
        steady && s2[5] && !s2[2] |-> output_indicator == 2'h2 && !faultOeN
            && !outputGoodOeN && thermalWarningOeN;
    endproperty
    a_overvolt: assert property (p_overvolt) else $error("overvoltage picture wrong");
    property p_pulse;
        (steady && s2 == 9'h0D0 && $stable(outputGoodOeN)) [*6] |-> 1'b0;
    endproperty
    a_pulse: assert property (p_pulse) else $error("good pin not pulsing");
    property p_warn;
        steady && s2 == 9'h0C8 |-> output_indicator == 2'h1 && faultOeN && outputGoodOeN
            && !thermalWarningOeN;
    endproperty
    a_warn: assert property (p_warn) else $error("warning picture wrong");
    property p_otfault;
        steady && s2[2] |-> output_indicator == 2'h2 && !faultOeN && !outputGoodOeN
            && !thermalWarningOeN;
    endproperty
    a_otfault: assert property (p_otfault) else $error("thermal fault picture wrong");
    property p_remote;
        steady && s2 == 9'h1C0 |-> input_indicator == 2'h1 && output_indicator == 2'h0
            && !outputGoodOeN && !mainOutputEnable;
    endproperty
    a_remote: assert property (p_remote) else $error("remote off picture wrong");
    property p_cap;
        steady |-> powerCapOeN == !s2[0];
    endproperty
    a_cap: assert property (p_cap) else $error("capacity pin wrong");
    property p_enable;
        mainOutputEnable |-> !$past(remoteOnOffN) && !$past(interlockN);
    endproperty
    a_enable: assert property (p_enable) else $error("output enabled while off");
endmodule : alsenc_checker
bind alsenc_top alsenc_checker chk (.*);

// >>> testbench/alsenc_ctrl_model.sv
// system controller model: drives control pins, resolves alarm pins
`timescale 1ns/100ps
module alsenc_ctrl_model (
    input wire logic wantOn,
    input wire logic wantIn,
    input wire logic [4:0] grounded,
    input wire logic faultOeN,
    input wire logic outputGoodOeN,
    input wire logic thermalWarningOeN,
    input wire logic powerCapOeN,
    input wire logic alert0OeN,
    input wire logic alert1OeN,
    output logic remoteOnOffN,
    output logic interlockN,
    output logic [2:0] bus_address_select,
    output logic dc_range_select,
    output logic standbySelectN,
    output logic [5:0] pinLevel
);
    // on shorts the remote pin to ground, releasing it turns off
    assign remoteOnOffN = !wantOn;
    // short pin mates last
    assign interlockN = !wantIn;
    // open straps read high through pull-ups
    assign bus_address_select = ~grounded[2:0];
    assign dc_range_select = ~grounded[3];
    assign standbySelectN = ~grounded[4];
    // pull-ups give high unless the device sinks the line
    assign pinLevel = {faultOeN, outputGoodOeN, thermalWarningOeN, powerCapOeN, alert0OeN,
        alert1OeN};
endmodule : alsenc_ctrl_model

// >>> testbench/alarm_led_status_encoder_bench.sv
// self-checking bench of the alarm and indicator encoder
`timescale 1ns/100ps
module alarm_led_status_encoder_bench;
    // one row: stimulus and the expected pin picture
    typedef struct packed {
        logic rmt;
        logic [2:0] ctrl;
        logic [7:0] cond;
        logic [3:0] code, inM, outM, goodM;
        logic [7:0] lvl;
    } alsenc_tbcase_s;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, mainOutputEnable, dcRangeNarrow, standbyHigh;
    alsenc_pkg::alsenc_cond_s condIn = 8'hC1;
    logic wantOn = 1'b1;
    logic wantIn = 1'b1;
    logic [4:0] grounded = 5'h00;
    logic remoteOnOffN, interlockN, dc_range_select, standbySelectN;
    logic [2:0] bus_address_select, busAddress;
    logic [1:0] input_indicator, output_indicator;
    logic faultOeN, outputGoodOeN, thermalWarningOeN, powerCapOeN, alert0OeN, alert1OeN;
    logic [5:0] pinLevel;
    int mismatches = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    alsenc_top #(.BLINK_HALF(4), .PULSE_HALF(3), .PG_LEAD_CYC(5)) DUT (.*, .faultN(),
        .output_good_n(), .thermal_warning_n(), .powerCapN(), .alert0N(), .alert1N(),
        .module_present());
    alsenc_ctrl_model ctrl (.*);
    // ==========================================
    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one slave access, held until waitrequest is seen low or 20 clocks pass
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0 && ++n < 20);
        q = avs_readdata;
        if (n >= 20)
            mismatches++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic test_done;
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // watchdog
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        test_done;
    end
    // ==========================================
    // main sequence
    initial
    begin
        alsenc_tbcase_s cases [14];
        alsenc_tbcase_s c;
        logic [4:0] gl [3];
        logic [3:0] inS, outS;
        logic [1:0] goodS;
        cases = '{36'h0_C0_0_2_2_2_F8, 36'h0_80_6_3_1_2_F8, 36'h0_00_7_1_1_1_F8,
            36'h0_E0_5_2_4_1_78, 36'h0_D0_3_2_3_3_F8, 36'h0_C8_1_2_2_2_B8,
            36'h0_C4_4_2_4_1_38, 36'h8_C0_2_2_1_1_F8, 36'h0_FC_4_2_4_1_38,
            36'h8_D0_2_2_1_1_F8, 36'h0_C2_0_2_2_1_F8, 36'h0_C1_0_2_2_2_D8,
            36'h7_C1_2_2_1_1_C0, 36'h0_C0_0_2_2_2_F8};
        gl = '{5'h00, 5'h15, 5'h0A};
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        // control register: reset, width, lanes, unmapped place
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        check(q, 32'h0);
        bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
        bus(1'b1, 4'h0, 32'h0, 4'h0);
        bus(1'b1, 4'h2, 32'h0, 4'hF);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        check(q, 32'h7);
        bus(1'b0, 4'h2, 32'h0, 4'hF);
        check(q, 32'h0);
        // strap pins open and grounded
        foreach (gl[j])
        begin
            grounded <= gl[j];
            repeat (3) @(posedge clk);
            check({standbyHigh, dcRangeNarrow, busAddress}, {gl[j][4:3], ~gl[j][2:0]});
        end
        // condition table, lamp values seen over a window
        foreach (cases[i])
        begin
            c = cases[i];
            bus(1'b1, 4'h0, {29'h0, c.ctrl}, 4'hF);
            wantOn <= !c.rmt;
            condIn <= c.cond;
            repeat (4) @(posedge clk);
            inS = 4'h0;
            outS = 4'h0;
            goodS = 2'h0;
            repeat (12)
            begin
                @(posedge clk);
                inS[input_indicator] = 1'b1;
                outS[output_indicator] = 1'b1;
                goodS[pinLevel[4]] = 1'b1;
            end
            check(inS, c.inM);
            check(outS, c.outM);
            check(goodS, c.goodM);
            check({pinLevel[5], pinLevel[3:0]}, c.lvl[7:3]);
            bus(1'b0, 4'h4, 32'h0, 4'hF);
            check(q, {20'h0, c.code, c.cond});
        end
        // main output gating
        check(mainOutputEnable, 1'b1);
        wantIn <= 1'b0;
        repeat (3) @(posedge clk);
        check(mainOutputEnable, 1'b0);
        wantIn <= 1'b1;
        wantOn <= 1'b0;
        repeat (3) @(posedge clk);
        check(mainOutputEnable, 1'b0);
        test_done;
    end
endmodule : alarm_led_status_encoder_bench
